// File: cmwc_consts.svh
// Constants of the CAN transceiver mode and wake control block.
// Assumes a 250 MHz core clock; times are converted to cycles here.
`ifndef CMWC_CONSTS_SVH
`define CMWC_CONSTS_SVH

`define CMWC_CLK_MHZ 250
// Times in microseconds, converted to cycles (least times round up)
`define CMWC_EN_DELAY_US 20
`define CMWC_EN_DELAY_CYC (`CMWC_EN_DELAY_US * `CMWC_CLK_MHZ)
`define CMWC_WAKE_DOM_MIN_US 1
`define CMWC_WAKE_DOM_MIN_CYC (`CMWC_WAKE_DOM_MIN_US * `CMWC_CLK_MHZ)
`define CMWC_WAKE_REC_MAX_US 1000
`define CMWC_WAKE_REC_MAX_CYC (`CMWC_WAKE_REC_MAX_US * `CMWC_CLK_MHZ)
`define CMWC_TX_TO_US 100
`define CMWC_TX_TO_CYC (`CMWC_TX_TO_US * `CMWC_CLK_MHZ)
`define CMWC_BUS_TO_US 100
`define CMWC_BUS_TO_CYC (`CMWC_BUS_TO_US * `CMWC_CLK_MHZ)
`define CMWC_CNT_W 20

// Transceiver mode field encodings
`define CMWC_TRX_OFF 2'h0
`define CMWC_TRX_WAKE 2'h1
`define CMWC_TRX_RXONLY 2'h2
`define CMWC_TRX_NORMAL 2'h3

`endif

// File: cmwc_pkg.sv
// Types of the CAN transceiver mode and wake control block.
// Assumes cmwc_consts.svh for the encodings.
`include "cmwc_consts.svh"

package cmwc_pkg;

    typedef enum logic [2:0] {
        CMWC_SBC_NORMAL,
        CMWC_SBC_STOP,
        CMWC_SBC_SLEEP,
        CMWC_SBC_RESTART,
        CMWC_SBC_FAILSAFE
    } cmwc_sbc_mode_t;

    // Wake event report toward the supply-management core
    typedef struct packed {
        logic int_req;
        logic bus_src;
        logic go_restart;
        logic wd_enable;
    } cmwc_wake_evt_t;

endpackage : cmwc_pkg

// File: cmwc_dom_timer.sv
// Saturating level-duration timer: counts cycles while a level holds.
// Assumes a synchronous level on the core clock.
`timescale 1ns/1ps
`default_nettype none

module cmwc_dom_timer (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    input wire logic [19:0] limit_i,
    output logic expired_o
);

    logic [19:0] cnt_ff;

    // Restarts when the qualifying level ends
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !level_i) begin
            cnt_ff <= 20'h0_0000;
        end else if (cnt_ff != limit_i) begin
            cnt_ff <= cnt_ff + 20'h0_0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            expired_o <= 1'b0;
        end else begin
            expired_o <= level_i && (cnt_ff == limit_i);
        end
    end

endmodule : cmwc_dom_timer

`default_nettype wire

// File: cmwc_ctrl.sv
// CAN transceiver mode, enabling, wake detection and timeout control.
// Assumes bus and tx pins arrive asynchronously; mode inputs are on core_clk_i.
//
// Operation
// - Reset enters off mode; bus driver released, bus not biased.
// - Off mode ignores all bus wake activity.
// - Normal mode accepted only in device normal or stop; bus biased.
// - Normal mode driver follows tx_input: low dominant, high recessive.
// - Low level during delay suppressed; next dominant after delay is sent.
// - Normal and receive-only present bus state on receive output.
// - Receive-only keeps driver off, reception on, bus biased.
// - Receive-only accepted only in device normal or stop.
// - Wake-capable accepted in stop, sleep, restart, normal; forced in fail-safe.
// - Wake pattern: two long dominant phases split by short recessive.
// - Bus wake holds receive output low until mode changes.
// - Mode field keeps reading wake-capable after a wake.
// - Detector rearms after leaving and re-entering wake-capable, or on stop, sleep or fail-safe entry.
// - Entering stop, sleep or fail-safe rearms wake detection.
// - Rearming does not need the wake flag cleared.
// - Wake in stop or normal: interrupt, status source, receive low.
// - Wake in stop enables watchdog when configured.
// - Wake in sleep, restart, fail-safe: go restart, no interrupt.
// - Long tx dominant in normal: driver off, fault flag set.
// - Driver returns once tx_input goes recessive; mode unchanged.
// - Long bus dominant in any mode sets fault flag.
`timescale 1ns/1ps
`default_nettype none
`include "cmwc_consts.svh"

module cmwc_ctrl
    import cmwc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic tx_input_i,
    input wire logic bus_dominant_i,
    input wire cmwc_sbc_mode_t sbc_mode_i,
    input wire logic mode_wr_i,
    input wire logic [1:0] mode_wdata_i,
    input wire logic watchdog_on_bus_wake_i,
    input wire logic fault_clr_i,
    input wire logic wake_flag_clr_i,
    output logic [1:0] trx_mode_o,
    output logic drive_dominant_o,
    output logic bias_half_o,
    output logic rx_o,
    output logic bus_wake_flag_o,
    output logic bus_fault_flag_o,
    output cmwc_wake_evt_t wake_evt_o
);

    // ******************************************************
    // Input synchronisers
    // ******************************************************
    logic tx_meta_ff;
    logic tx_sync_ff;
    logic bus_meta_ff;
    logic bus_sync_ff;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_meta_ff <= 1'b1;
            tx_sync_ff <= 1'b1;
            bus_meta_ff <= 1'b0;
            bus_sync_ff <= 1'b0;
        end else begin
            tx_meta_ff <= tx_input_i;
            tx_sync_ff <= tx_meta_ff;
            bus_meta_ff <= bus_dominant_i;
            bus_sync_ff <= bus_meta_ff;
        end
    end

    // ******************************************************
    // Mode selection
    // ******************************************************
    function automatic logic mode_allowed(input logic [1:0] m, input cmwc_sbc_mode_t s);
        logic ok;
        ok = 1'b0;
        unique case (m)
            `CMWC_TRX_OFF: ok = 1'b1;
            `CMWC_TRX_NORMAL, `CMWC_TRX_RXONLY:
                ok = (s == CMWC_SBC_NORMAL) || (s == CMWC_SBC_STOP);
            `CMWC_TRX_WAKE: ok = (s != CMWC_SBC_FAILSAFE);
        endcase
        return ok;
    endfunction : mode_allowed

    function automatic logic is_low_power(input cmwc_sbc_mode_t s);
        return (s == CMWC_SBC_STOP) || (s == CMWC_SBC_SLEEP) || (s == CMWC_SBC_FAILSAFE);
    endfunction : is_low_power

    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;
    cmwc_sbc_mode_t sbc_prev_ff;
    logic sbc_enter_lp;
    logic mode_change;

    assign sbc_enter_lp = is_low_power(sbc_mode_i) && (sbc_mode_i != sbc_prev_ff);

    always_comb begin
        nxt_mode = mode_ff;
        if (sbc_mode_i == CMWC_SBC_FAILSAFE) begin
            nxt_mode = `CMWC_TRX_WAKE;
        end else if (mode_wr_i && mode_allowed(mode_wdata_i, sbc_mode_i)) begin
            nxt_mode = mode_wdata_i;
        end
    end

    assign mode_change = (nxt_mode != mode_ff);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mode_ff <= `CMWC_TRX_OFF;
            sbc_prev_ff <= CMWC_SBC_NORMAL;
        end else begin
            mode_ff <= nxt_mode;
            sbc_prev_ff <= sbc_mode_i;
        end
    end

    // ******************************************************
    // Duration timers
    // ******************************************************
    logic en_run;
    logic en_done;
    logic wake_dom_long;
    logic wake_rec_long;
    logic tx_to;
    logic bus_to;

    assign en_run = (mode_ff == `CMWC_TRX_NORMAL) && !mode_change;

    // Enabling delay restarts whenever normal mode is (re)entered
    cmwc_dom_timer u_en_timer (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(en_run),
        .limit_i(20'(`CMWC_EN_DELAY_CYC)),
        .expired_o(en_done)
    );

    cmwc_dom_timer u_wake_dom (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(bus_sync_ff),
        .limit_i(20'(`CMWC_WAKE_DOM_MIN_CYC)),
        .expired_o(wake_dom_long)
    );

    cmwc_dom_timer u_wake_rec (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(!bus_sync_ff),
        .limit_i(20'(`CMWC_WAKE_REC_MAX_CYC)),
        .expired_o(wake_rec_long)
    );

    cmwc_dom_timer u_tx_to (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(!tx_sync_ff && (mode_ff == `CMWC_TRX_NORMAL)),
        .limit_i(20'(`CMWC_TX_TO_CYC)),
        .expired_o(tx_to)
    );

    cmwc_dom_timer u_bus_to (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(bus_sync_ff),
        .limit_i(20'(`CMWC_BUS_TO_CYC)),
        .expired_o(bus_to)
    );

    // ******************************************************
    // Enabling sequence and transmit path
    // ******************************************************
    logic tx_armed_ff;
    logic tx_blocked_ff;

    // Low held through the delay stays blocked until a recessive level is seen
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !en_run) begin
            tx_armed_ff <= 1'b0;
        end else if (en_done && tx_sync_ff) begin
            tx_armed_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_blocked_ff <= 1'b0;
        end else if (tx_to) begin
            tx_blocked_ff <= 1'b1;
        end else if (tx_sync_ff) begin
            tx_blocked_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            drive_dominant_o <= 1'b0;
        end else begin
            drive_dominant_o <= (mode_ff == `CMWC_TRX_NORMAL) && tx_armed_ff
                && !tx_blocked_ff && !tx_to && !tx_sync_ff;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bias_half_o <= 1'b0;
        end else begin
            bias_half_o <= (mode_ff == `CMWC_TRX_NORMAL)
                || (mode_ff == `CMWC_TRX_RXONLY);
        end
    end

    // ******************************************************
    // Wake pattern detection
    // ******************************************************
    typedef enum logic [1:0] {WK_IDLE, WK_DOM1, WK_REC, WK_DONE} cmwc_wk_t;
    cmwc_wk_t wk_ff;
    cmwc_wk_t nxt_wk;
    logic wake_hit;

    always_comb begin
        nxt_wk = wk_ff;
        unique case (wk_ff)
            WK_IDLE: if (wake_dom_long) nxt_wk = WK_DOM1;
            WK_DOM1: if (!bus_sync_ff) nxt_wk = WK_REC;
            WK_REC: if (wake_rec_long) nxt_wk = WK_IDLE;
                else if (wake_dom_long) nxt_wk = WK_DONE;
            WK_DONE: nxt_wk = WK_DONE;
        endcase
    end

    assign wake_hit = (wk_ff == WK_REC) && (nxt_wk == WK_DONE);

    // Detector idles outside wake-capable; DONE survives until rearmed
    // Next mode is used so no stale pattern completes after leaving the mode
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || (nxt_mode != `CMWC_TRX_WAKE)) begin
            wk_ff <= WK_IDLE;
        end else if (sbc_enter_lp) begin
            wk_ff <= WK_IDLE;
        end else begin
            wk_ff <= nxt_wk;
        end
    end

    // ******************************************************
    // Receive output and wake signalling
    // ******************************************************
    logic wake_rx_low_ff;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || mode_change) begin
            wake_rx_low_ff <= 1'b0;
        end else if (wake_hit) begin
            wake_rx_low_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_o <= 1'b1;
        end else if (wake_rx_low_ff || wake_hit) begin
            rx_o <= 1'b0;
        end else if ((mode_ff == `CMWC_TRX_NORMAL) || (mode_ff == `CMWC_TRX_RXONLY)) begin
            rx_o <= !bus_sync_ff;
        end else begin
            rx_o <= 1'b1;
        end
    end

    // Set wins over clear
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus_wake_flag_o <= 1'b0;
        end else if (wake_hit) begin
            bus_wake_flag_o <= 1'b1;
        end else if (wake_flag_clr_i) begin
            bus_wake_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus_fault_flag_o <= 1'b0;
        end else if (tx_to || bus_to) begin
            bus_fault_flag_o <= 1'b1;
        end else if (fault_clr_i) begin
            bus_fault_flag_o <= 1'b0;
        end
    end

    logic stop_or_norm;
    assign stop_or_norm = (sbc_mode_i == CMWC_SBC_STOP) || (sbc_mode_i == CMWC_SBC_NORMAL);

    // One-cycle event pulses to the supply-management core
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wake_evt_o <= '0;
        end else begin
            wake_evt_o.int_req <= wake_hit && stop_or_norm;
            wake_evt_o.bus_src <= wake_hit;
            wake_evt_o.go_restart <= wake_hit && !stop_or_norm;
            wake_evt_o.wd_enable <= wake_hit && (sbc_mode_i == CMWC_SBC_STOP)
                && watchdog_on_bus_wake_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            trx_mode_o <= `CMWC_TRX_OFF;
        end else begin
            trx_mode_o <= nxt_mode;
        end
    end

    // ******************************************************
    // Assertions
    // ******************************************************
    a_off_no_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (mode_ff != `CMWC_TRX_NORMAL) |=> !drive_dominant_o)
        else $error("driver active outside normal mode");
    a_off_no_wake: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (mode_ff == `CMWC_TRX_OFF) |-> !wake_hit)
        else $error("wake seen in off mode");
    a_wake_rx_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wake_hit && !mode_change |=> !rx_o ##1 (!rx_o || mode_change))
        else $error("receive output not held low after wake");
    a_wake_int: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wake_hit |=> (wake_evt_o.int_req == $past(stop_or_norm)))
        else $error("interrupt request mismatch");
    a_wake_restart: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wake_hit && !stop_or_norm |=> wake_evt_o.go_restart && !wake_evt_o.int_req)
        else $error("restart request missing");
    a_failsafe_mode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (sbc_mode_i == CMWC_SBC_FAILSAFE) |=> (mode_ff == `CMWC_TRX_WAKE))
        else $error("fail-safe did not force wake-capable");
    a_illegal_normal: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        mode_wr_i && (mode_wdata_i == `CMWC_TRX_NORMAL) && !stop_or_norm
        && (sbc_mode_i != CMWC_SBC_FAILSAFE)
        |=> ($past(mode_ff) == `CMWC_TRX_NORMAL) == (mode_ff == `CMWC_TRX_NORMAL))
        else $error("normal mode taken in wrong device mode");
    a_tx_timeout: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tx_to |=> bus_fault_flag_o && !drive_dominant_o)
        else $error("tx timeout not handled");
    a_bus_clamp: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        bus_to && !mode_change |=> bus_fault_flag_o && $stable(mode_ff))
        else $error("bus clamp not flagged");

endmodule : cmwc_ctrl

`default_nettype wire

// File: cmwc_can_peer.sv
// Behavioural CAN protocol controller driving the transmit input.
// Assumes trx_mode_i comes straight from the transceiver block on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "cmwc_consts.svh"

module cmwc_can_peer (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] trx_mode_i,
    input wire logic want_dom_i,
    input wire logic early_low_i,
    output logic tx_input_o
);
    // ************************************************************
    // Enabling delay tracking
    // ************************************************************
    int en_cnt;

    always @(posedge core_clk_i) begin
        if (!rst_n_i || trx_mode_i != `CMWC_TRX_NORMAL) begin
            en_cnt <= 0;
        end else if (en_cnt < `CMWC_EN_DELAY_CYC + 1) begin
            en_cnt <= en_cnt + 1;
        end
    end

    // Early low is a fault that only a scenario commands
    always_comb begin
        if (trx_mode_i == `CMWC_TRX_NORMAL && en_cnt < `CMWC_EN_DELAY_CYC + 1) begin
            tx_input_o = !early_low_i;
        end else begin
            tx_input_o = !(want_dom_i | early_low_i);
        end
    end
endmodule : cmwc_can_peer
`default_nettype wire

// File: can_transceiver_mode_wake_control_tb_top.sv
// Self-checking bench for the transceiver mode and wake control block.
// Assumes the default timing header; both dominant timeouts are exercised.
`timescale 1ns/1ps
`default_nettype none
`include "cmwc_consts.svh"

module can_transceiver_mode_wake_control_tb_top
    import cmwc_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic tx_input, bus_ext = 1'b0, bus_dom, mode_wr = 1'b0, wd_cfg = 1'b0, flag_clr = 1'b0;
    logic want_dom = 1'b0, early_low = 1'b0, evt_clr = 1'b0, fault_clr = 1'b0;
    logic [1:0] mode_wdata = 2'h0, trx_mode;
    logic drive, bias, rx, wake_flag, fault_flag;
    cmwc_sbc_mode_t sbc = CMWC_SBC_NORMAL;
    cmwc_wake_evt_t evt, evt_seen;
    int err_count = 0, comparisons = 0, cycles = 0, exp_mode = 0;

    // Bus is dominant when our driver or another node pulls it
    assign bus_dom = drive | bus_ext;

    cmwc_ctrl dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tx_input_i(tx_input),
        .bus_dominant_i(bus_dom), .sbc_mode_i(sbc), .mode_wr_i(mode_wr),
        .mode_wdata_i(mode_wdata), .watchdog_on_bus_wake_i(wd_cfg), .fault_clr_i(fault_clr),
        .wake_flag_clr_i(flag_clr), .trx_mode_o(trx_mode), .drive_dominant_o(drive),
        .bias_half_o(bias), .rx_o(rx), .bus_wake_flag_o(wake_flag),
        .bus_fault_flag_o(fault_flag), .wake_evt_o(evt));

    cmwc_can_peer peer_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .trx_mode_i(trx_mode),
        .want_dom_i(want_dom), .early_low_i(early_low), .tx_input_o(tx_input));

    // ************************************************************
    // Clock, event capture, timeout
    // ************************************************************
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    // One-cycle pulses are easy to miss, so they are collected here
    always @(posedge core_clk_i) begin
        evt_seen <= (evt_clr || !rst_n_i) ? cmwc_wake_evt_t'(4'h0) : (evt_seen | evt);
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_count++;
            print_verdict();
        end
    end

    // ************************************************************
    // Tasks and reference model
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick

    function automatic int nxt_mode(input cmwc_sbc_mode_t s, input int cur, input int c);
        if (s == CMWC_SBC_FAILSAFE) return 1;
        if (c == 0 || c == 1) return c;
        if (s == CMWC_SBC_NORMAL || s == CMWC_SBC_STOP) return c;
        return cur;
    endfunction : nxt_mode

    task automatic wr_mode(input logic [1:0] c);
        @(posedge core_clk_i);
        mode_wr <= 1'b1;
        mode_wdata <= c;
        @(posedge core_clk_i);
        mode_wr <= 1'b0;
        tick(2);
        exp_mode = nxt_mode(sbc, exp_mode, c);
        chk(trx_mode, exp_mode);
    endtask : wr_mode

    task automatic set_sbc(input cmwc_sbc_mode_t m);
        @(posedge core_clk_i);
        sbc <= m;
        evt_clr <= 1'b1;
        @(posedge core_clk_i);
        evt_clr <= 1'b0;
        tick(2);
        if (m == CMWC_SBC_FAILSAFE) exp_mode = 1;
    endtask : set_sbc

    // Two long dominant phases split by a short recessive gap
    task automatic wake_pat();
        @(posedge core_clk_i);
        bus_ext <= 1'b1;
        repeat (300) @(posedge core_clk_i);
        bus_ext <= 1'b0;
        repeat (100) @(posedge core_clk_i);
        bus_ext <= 1'b1;
        repeat (300) @(posedge core_clk_i);
        bus_ext <= 1'b0;
        tick(10);
    endtask : wake_pat

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        cmwc_sbc_mode_t s;
        void'($urandom(32'hdc6e));
        tick(12);
        rst_n_i <= 1'b1;
        tick(2);
        chk({trx_mode, drive, bias, rx, wake_flag, fault_flag}, 32'h0000_0004);
        wake_pat();
        chk({rx, wake_flag, evt_seen}, 32'h0000_0020);
        for (int i = 0; i < 40; i++) begin
            s = cmwc_sbc_mode_t'($urandom % 5);
            set_sbc(s);
            wr_mode(2'($urandom));
            chk(trx_mode, exp_mode);
        end
        set_sbc(CMWC_SBC_NORMAL);
        wr_mode(2'h0);
        wr_mode(2'h1);
        wake_pat();
        chk({trx_mode, rx, wake_flag}, 32'h0000_0005);
        chk(evt_seen, 32'h0000_000c);
        @(posedge core_clk_i);
        flag_clr <= 1'b1;
        evt_clr <= 1'b1;
        @(posedge core_clk_i);
        flag_clr <= 1'b0;
        evt_clr <= 1'b0;
        wake_pat();
        chk({trx_mode, rx, wake_flag, evt_seen}, 32'h0000_0040);
        wr_mode(2'h0);
        chk(rx, 1'b1);
        wr_mode(2'h1);
        wake_pat();
        chk({rx, wake_flag}, 32'h0000_0001);
        wd_cfg <= 1'b1;
        set_sbc(CMWC_SBC_STOP);
        wake_pat();
        chk(evt_seen, 32'h0000_000d);
        set_sbc(CMWC_SBC_SLEEP);
        wake_pat();
        chk({rx, evt_seen}, 32'h0000_0006);
        set_sbc(CMWC_SBC_NORMAL);
        early_low <= 1'b1;
        wr_mode(2'h3);
        chk(bias, 1'b1);
        tick(`CMWC_EN_DELAY_CYC + 10);
        chk(drive, 1'b0);
        early_low <= 1'b0;
        tick(10);
        want_dom <= 1'b1;
        tick(8);
        chk({drive, rx}, 32'h0000_0002);
        want_dom <= 1'b0;
        tick(8);
        chk({drive, rx}, 32'h0000_0001);
        want_dom <= 1'b1;
        tick(`CMWC_TX_TO_CYC + 10);
        chk({drive, fault_flag, trx_mode}, 32'h0000_0007);
        want_dom <= 1'b0;
        tick(8);
        want_dom <= 1'b1;
        tick(8);
        chk({drive, trx_mode}, 32'h0000_0007);
        want_dom <= 1'b0;
        tick(8);
        @(posedge core_clk_i);
        fault_clr <= 1'b1;
        @(posedge core_clk_i);
        fault_clr <= 1'b0;
        tick(2);
        chk(fault_flag, 1'b0);
        wr_mode(2'h2);
        want_dom <= 1'b1;
        tick(8);
        chk({drive, bias, rx}, 32'h0000_0003);
        bus_ext <= 1'b1;
        tick(8);
        chk(rx, 1'b0);
        tick(`CMWC_BUS_TO_CYC);
        chk({fault_flag, trx_mode}, 32'h0000_0006);
        bus_ext <= 1'b0;
        want_dom <= 1'b0;
        tick(8);
        print_verdict();
    end
endmodule : can_transceiver_mode_wake_control_tb_top
`default_nettype wire
